//--- mist_core_model.sv
`timescale 1ns/100ps
module mist_core_model (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic irq_req_in,
    input  wire logic slow_in,
    input  wire logic return_from_interrupt_en_in,
    output logic      vec_ack_out,
    output logic      return_from_interrupt_out
);
    logic [3:0] wait_ff;
    logic [3:0] svc_ff;
    // one vector at a time; handler length fixed so the bench can time reads
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wait_ff     <= 4'h0;
            svc_ff      <= 4'h0;
            vec_ack_out <= 1'b0;
            return_from_interrupt_out    <= 1'b0;
        end else begin
            vec_ack_out <= 1'b0;
            return_from_interrupt_out    <= 1'b0;
            if (svc_ff != 4'h0) begin
                svc_ff   <= svc_ff - 4'h1;
                return_from_interrupt_out <= (svc_ff == 4'h1) && return_from_interrupt_en_in;
            end else if (irq_req_in && !vec_ack_out) begin
                if (wait_ff == (slow_in ? 4'h5 : 4'h0)) begin
                    vec_ack_out <= 1'b1;
                    wait_ff     <= 4'h0;
                    svc_ff      <= 4'h6;
                end else begin
                    wait_ff <= wait_ff + 4'h1;
                end
            end else begin
                wait_ff <= 4'h0;
            end
        end
    end
endmodule

//--- mist_irq.sv
`timescale 1ns/100ps
// Behaviour
// - multi-function flag sets when the grouped request of enabled timer-module match flags rises.
// - global and multi-function enabled, stack not full, multi-function flag set: call multi-function vector.
// - servicing multi-function clears its flag and the global enable.
// - time-base divider overflow sets that time-base request flag.
// - time-base vectors only with global and own enable set, stack not full.
// - servicing a time-base clears its flag and the global enable.
// - time-base 0 period is clock over 256..32768 by 3-bit code; reset longest.
// - time-base 1 period is clock over 4096..32768 by 2-bit code; reset longest.
// - clock select: clear picks time-base oscillator, set picks system clock over four.
// - each finished EEPROM write sets the EEPROM request flag.
// - EEPROM vectors only with global and EEPROM enable set, stack not full.
// - servicing EEPROM clears global enable and the EEPROM flag.
// - timer module has P and A match flags with matching enables.
// - timer-module requests reach only the multi-function vector.
// - match vectors only with global, own and multi-function enable, stack not full.
// - global enable clear inhibits all vectoring; flags still record.
// - any request flag rising wakes the device, enables ignored.
// - a set flag stays set until serviced or cleared by software.
// - return-from-interrupt sets global enable again; plain return leaves it.
module mist_irq
    import mist_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    // register port
    input  wire logic [2:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    // peripheral events, one-cycle pulses on sys_clk_in
    input  wire logic       match_p_evt_in,
    input  wire logic       match_a_evt_in,
    input  wire logic       eeprom_done_in,
    // dedicated time-base oscillator, asynchronous
    input  wire logic       timebase_osc_clock_in,
    // processor core
    input  wire logic       stack_full_in,
    input  wire logic       vec_ack_in,
    input  wire logic       return_from_interrupt_in,
    output logic            irq_req_out,
    output logic      [1:0] irq_vec_out,
    output logic            wake_out
);

    ////////////////////////////////////////////////////////////////////////
    // state

    logic       global_int_en_ff;
    logic       timebase0_req_flag_ff;
    logic       timebase1_req_flag_ff;
    logic       timebase0_int_en_ff;
    logic       timebase1_int_en_ff;
    logic       eeprom_req_flag_ff;
    logic       eeprom_int_en_ff;
    logic       multifunc_req_flag_ff;
    logic       multifunc_int_en_ff;
    logic       match_p_req_flag_ff;
    logic       match_a_req_flag_ff;
    logic       match_p_int_en_ff;
    logic       match_a_int_en_ff;
    logic       timebase_master_on_ff;
    logic       timebase_clock_select_ff;
    logic [1:0] timebase1_period_sel_ff;
    logic [2:0] timebase0_period_sel_ff;
    logic       grp_req_ff;

    logic       nxt_global_int_en;
    logic       nxt_timebase0_req_flag;
    logic       nxt_timebase1_req_flag;
    logic       nxt_eef;
    logic       nxt_mff;
    logic       nxt_mpf;
    logic       nxt_maf;
    logic       nxt_grp_req;
    logic       nxt_irq_req;
    mist_vec_t  nxt_vec;
    logic [5:0] cur_flags;
    logic [5:0] nxt_flags;

    logic wr_intc0;
    logic wr_intc1;
    logic wr_mfi;
    logic wr_tbc;
    logic ack_mf;
    logic ack_tb0;
    logic ack_tb1;
    logic ack_ee;

    assign wr_intc0 = reg_wr_in && (reg_addr_in == MIST_ADDR_INTC0);
    assign wr_intc1 = reg_wr_in && (reg_addr_in == MIST_ADDR_INTC1);
    assign wr_mfi   = reg_wr_in && (reg_addr_in == MIST_ADDR_MFI);
    assign wr_tbc   = reg_wr_in && (reg_addr_in == MIST_ADDR_TBC);

    // the core acknowledges the vector currently shown on irq_vec_out
    assign ack_mf  = vec_ack_in && irq_req_out && (irq_vec_out == MIST_VEC_MF);
    assign ack_tb0 = vec_ack_in && irq_req_out && (irq_vec_out == MIST_VEC_TB0);
    assign ack_tb1 = vec_ack_in && irq_req_out && (irq_vec_out == MIST_VEC_TB1);
    assign ack_ee  = vec_ack_in && irq_req_out && (irq_vec_out == MIST_VEC_EE);

    ////////////////////////////////////////////////////////////////////////
    // time-base clock and dividers

    logic       osc_sync1_ff;
    logic       osc_sync2_ff;
    logic       osc_prev_ff;
    logic [1:0] sys_div_ff;
    logic       tb_tick;
    logic [MIST_TB_CNT_W-1:0] tb_cnt_ff;
    logic [MIST_TB_CNT_W-1:0] tb0_mask;
    logic [MIST_TB_CNT_W-1:0] tb1_mask;
    logic       tb0_ovf;
    logic       tb1_ovf;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            osc_sync1_ff <= 1'b0;
            osc_sync2_ff <= 1'b0;
            osc_prev_ff  <= 1'b0;
        end else begin
            osc_sync1_ff <= timebase_osc_clock_in;
            osc_sync2_ff <= osc_sync1_ff;
            osc_prev_ff  <= osc_sync2_ff;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sys_div_ff <= 2'h0;
        end else begin
            sys_div_ff <= sys_div_ff + 2'h1;
        end
    end

    // oscillator must run below half the system rate to be seen
    assign tb_tick = timebase_clock_select_ff ? (sys_div_ff == MIST_SYS_DIV_LAST)
                                              : (osc_sync2_ff && !osc_prev_ff);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            tb_cnt_ff <= '0;
        end else if (!timebase_master_on_ff) begin
            tb_cnt_ff <= '0;
        end else if (tb_tick) begin
            tb_cnt_ff <= tb_cnt_ff + 1'b1;
        end
    end

    // low (base + code) bits all ones at a tick marks the period end
    assign tb0_mask = MIST_TB_CNT_W'((32'h1 << (MIST_TB0_LOG2_MIN + 32'(timebase0_period_sel_ff)))
                      - 32'h1);
    assign tb1_mask = MIST_TB_CNT_W'((32'h1 << (MIST_TB1_LOG2_MIN + 32'(timebase1_period_sel_ff)))
                      - 32'h1);
    assign tb0_ovf = timebase_master_on_ff && tb_tick && ((tb_cnt_ff & tb0_mask) == tb0_mask);
    assign tb1_ovf = timebase_master_on_ff && tb_tick && ((tb_cnt_ff & tb1_mask) == tb1_mask);

    ////////////////////////////////////////////////////////////////////////
    // next flag values: service clear, then software write, then hardware set

    always_comb begin
        nxt_timebase0_req_flag = timebase0_req_flag_ff;
        if (ack_tb0) begin
            nxt_timebase0_req_flag = 1'b0;
        end
        if (wr_intc0) begin
            nxt_timebase0_req_flag = reg_wdata_in[MIST_B_TIMEBASE0_REQ_FLAG];
        end
        if (tb0_ovf) begin
            nxt_timebase0_req_flag = 1'b1;
        end

        nxt_timebase1_req_flag = timebase1_req_flag_ff;
        if (ack_tb1) begin
            nxt_timebase1_req_flag = 1'b0;
        end
        if (wr_intc0) begin
            nxt_timebase1_req_flag = reg_wdata_in[MIST_B_TIMEBASE1_REQ_FLAG];
        end
        if (tb1_ovf) begin
            nxt_timebase1_req_flag = 1'b1;
        end

        nxt_eef = eeprom_req_flag_ff;
        if (ack_ee) begin
            nxt_eef = 1'b0;
        end
        if (wr_intc1) begin
            nxt_eef = reg_wdata_in[MIST_B_DEF];
        end
        if (eeprom_done_in) begin
            nxt_eef = 1'b1;
        end

        // servicing leaves these alone; only software clears them
        nxt_mpf = match_p_req_flag_ff;
        nxt_maf = match_a_req_flag_ff;
        if (wr_mfi) begin
            nxt_mpf = reg_wdata_in[MIST_B_MPF];
            nxt_maf = reg_wdata_in[MIST_B_MAF];
        end
        if (match_p_evt_in) begin
            nxt_mpf = 1'b1;
        end
        if (match_a_evt_in) begin
            nxt_maf = 1'b1;
        end

        // grouped request level; its rising edge sets the multi-function flag
        nxt_grp_req = (nxt_mpf && match_p_int_en_ff) || (nxt_maf && match_a_int_en_ff);
        nxt_mff = multifunc_req_flag_ff;
        if (ack_mf) begin
            nxt_mff = 1'b0;
        end
        if (wr_intc1) begin
            nxt_mff = reg_wdata_in[MIST_B_MFF];
        end
        if (nxt_grp_req && !grp_req_ff) begin
            nxt_mff = 1'b1;
        end

        nxt_global_int_en = global_int_en_ff;
        if (return_from_interrupt_in) begin
            nxt_global_int_en = 1'b1;
        end
        if (wr_intc0) begin
            nxt_global_int_en = reg_wdata_in[MIST_B_EMI];
        end
        if (vec_ack_in && irq_req_out) begin
            nxt_global_int_en = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // vector selection, from next state so a serviced source never repeats

    always_comb begin
        nxt_vec     = MIST_VEC_MF;
        nxt_irq_req = 1'b0;
        if (nxt_global_int_en && !stack_full_in) begin
            if (nxt_mff && multifunc_int_en_ff) begin
                nxt_vec     = MIST_VEC_MF;
                nxt_irq_req = 1'b1;
            end else if (nxt_timebase0_req_flag && timebase0_int_en_ff) begin
                nxt_vec     = MIST_VEC_TB0;
                nxt_irq_req = 1'b1;
            end else if (nxt_timebase1_req_flag && timebase1_int_en_ff) begin
                nxt_vec     = MIST_VEC_TB1;
                nxt_irq_req = 1'b1;
            end else if (nxt_eef && eeprom_int_en_ff) begin
                nxt_vec     = MIST_VEC_EE;
                nxt_irq_req = 1'b1;
            end
        end
    end

    assign cur_flags = {match_a_req_flag_ff, match_p_req_flag_ff, multifunc_req_flag_ff,
                        eeprom_req_flag_ff, timebase1_req_flag_ff, timebase0_req_flag_ff};
    assign nxt_flags = {nxt_maf, nxt_mpf, nxt_mff, nxt_eef, nxt_timebase1_req_flag, nxt_timebase0_req_flag};

    ////////////////////////////////////////////////////////////////////////
    // flag and enable registers

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            global_int_en_ff      <= 1'b0;
            timebase0_req_flag_ff <= 1'b0;
            timebase1_req_flag_ff <= 1'b0;
            eeprom_req_flag_ff    <= 1'b0;
            multifunc_req_flag_ff <= 1'b0;
            match_p_req_flag_ff   <= 1'b0;
            match_a_req_flag_ff   <= 1'b0;
            grp_req_ff            <= 1'b0;
        end else begin
            global_int_en_ff      <= nxt_global_int_en;
            timebase0_req_flag_ff <= nxt_timebase0_req_flag;
            timebase1_req_flag_ff <= nxt_timebase1_req_flag;
            eeprom_req_flag_ff    <= nxt_eef;
            multifunc_req_flag_ff <= nxt_mff;
            match_p_req_flag_ff   <= nxt_mpf;
            match_a_req_flag_ff   <= nxt_maf;
            grp_req_ff            <= nxt_grp_req;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            timebase0_int_en_ff <= 1'b0;
            timebase1_int_en_ff <= 1'b0;
            eeprom_int_en_ff    <= 1'b0;
            multifunc_int_en_ff <= 1'b0;
            match_p_int_en_ff   <= 1'b0;
            match_a_int_en_ff   <= 1'b0;
        end else begin
            if (wr_intc0) begin
                timebase0_int_en_ff <= reg_wdata_in[MIST_B_TIMEBASE0_INT_EN];
                timebase1_int_en_ff <= reg_wdata_in[MIST_B_TIMEBASE1_INT_EN];
            end
            if (wr_intc1) begin
                eeprom_int_en_ff    <= reg_wdata_in[MIST_B_DEE];
                multifunc_int_en_ff <= reg_wdata_in[MIST_B_MFE];
            end
            if (wr_mfi) begin
                match_p_int_en_ff   <= reg_wdata_in[MIST_B_MPE];
                match_a_int_en_ff   <= reg_wdata_in[MIST_B_MAE];
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            timebase_master_on_ff    <= 1'b0;
            timebase_clock_select_ff <= 1'b0;
            timebase1_period_sel_ff  <= MIST_RST_TB1SEL;
            timebase0_period_sel_ff  <= MIST_RST_TB0SEL;
        end else if (wr_tbc) begin
            timebase_master_on_ff    <= reg_wdata_in[MIST_B_TIMEBASE_MASTER_ON];
            timebase_clock_select_ff <= reg_wdata_in[MIST_B_TIMEBASE_CLOCK_SELECT];
            timebase1_period_sel_ff  <= reg_wdata_in[MIST_B_TB1L +: 2];
            timebase0_period_sel_ff  <= reg_wdata_in[MIST_B_TB0L +: 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core side outputs

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            irq_req_out <= 1'b0;
            irq_vec_out <= MIST_VEC_MF;
            wake_out    <= 1'b0;
        end else begin
            irq_req_out <= nxt_irq_req;
            irq_vec_out <= nxt_vec;
            wake_out    <= |(nxt_flags & ~cur_flags);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data only in the cycle after the strobe

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (!reg_rd_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_addr_in == MIST_ADDR_INTC0) begin
            reg_rdata_out <= {1'b0, timebase1_req_flag_ff, timebase0_req_flag_ff, 1'b0,
                              timebase1_int_en_ff, timebase0_int_en_ff, 1'b0, global_int_en_ff};
        end else if (reg_addr_in == MIST_ADDR_INTC1) begin
            reg_rdata_out <= {2'b00, eeprom_req_flag_ff, multifunc_req_flag_ff, 2'b00,
                              eeprom_int_en_ff, multifunc_int_en_ff};
        end else if (reg_addr_in == MIST_ADDR_MFI) begin
            reg_rdata_out <= {2'b00, match_a_req_flag_ff, match_p_req_flag_ff, 2'b00,
                              match_a_int_en_ff, match_p_int_en_ff};
        end else if (reg_addr_in == MIST_ADDR_TBC) begin
            reg_rdata_out <= {timebase_master_on_ff, timebase_clock_select_ff,
                              timebase1_period_sel_ff, 1'b0, timebase0_period_sel_ff};
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

endmodule

//--- mist_irq_checker.sv
`timescale 1ns/100ps
module mist_irq_checker
    import mist_pkg::*;
(
    input wire logic       sys_clk_in,
    input wire logic       rst_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       match_p_evt_in,
    input wire logic       match_a_evt_in,
    input wire logic       eeprom_done_in,
    input wire logic       timebase_osc_clock_in,
    input wire logic       stack_full_in,
    input wire logic       vec_ack_in,
    input wire logic       return_from_interrupt_in,
    input wire logic       irq_req_out,
    input wire logic [1:0] irq_vec_out,
    input wire logic       wake_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence ack_taken;
        vec_ack_in && irq_req_out;
    endsequence
    sequence core_quiet;
        !return_from_interrupt_in && !reg_wr_in;
    endsequence
    sequence tbc_wr_rd;
        reg_wr_in && reg_addr_in == MIST_ADDR_TBC ##1 reg_rd_in && reg_addr_in == MIST_ADDR_TBC;
    endsequence
    chk_reset_quiet: assert property ($fell(rst_in) |-> !irq_req_out && !wake_out
        && irq_vec_out == 2'b00 && reg_rdata_out == 8'h00) else $error("outputs busy after reset");
    chk_ack_drop: assert property (ack_taken |=> !irq_req_out)
        else $error("request stays after vector taken");
    chk_ack_quiet: assert property (ack_taken ##1 core_quiet [*2] |-> !irq_req_out)
        else $error("request returns without re-enable");
    chk_stack_block: assert property (stack_full_in [*2] |-> !irq_req_out)
        else $error("request while stack full");
    chk_global_off: assert property (reg_wr_in && reg_addr_in == MIST_ADDR_INTC0
        && !reg_wdata_in[MIST_B_EMI] && !return_from_interrupt_in |=> !irq_req_out)
        else $error("request with global enable clear");
    chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside its cycle");
    chk_unmapped_read: assert property (reg_rd_in && reg_addr_in[2]
        |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    chk_tbc_readback: assert property (tbc_wr_rd |=> reg_rdata_out == ($past(reg_wdata_in, 2)
        & 8'hF7)) else $error("control readback differs");
endmodule
bind mist_irq mist_irq_checker u_chk (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .match_p_evt_in, .match_a_evt_in, .eeprom_done_in,
    .timebase_osc_clock_in, .stack_full_in, .vec_ack_in, .return_from_interrupt_in,
    .irq_req_out, .irq_vec_out, .wake_out);

//--- mist_pkg.sv
package mist_pkg;

    // register indices on the plain register port
    localparam logic [2:0] MIST_ADDR_INTC0 = 3'h0;
    localparam logic [2:0] MIST_ADDR_INTC1 = 3'h1;
    localparam logic [2:0] MIST_ADDR_MFI   = 3'h2;
    localparam logic [2:0] MIST_ADDR_TBC   = 3'h3;

    // interrupt control 0 fields
    localparam int MIST_B_TIMEBASE1_REQ_FLAG = 6;
    localparam int MIST_B_TIMEBASE0_REQ_FLAG = 5;
    localparam int MIST_B_TIMEBASE1_INT_EN = 3;
    localparam int MIST_B_TIMEBASE0_INT_EN = 2;
    localparam int MIST_B_EMI  = 0;

    // interrupt control 1 fields
    localparam int MIST_B_DEF  = 5;
    localparam int MIST_B_MFF  = 4;
    localparam int MIST_B_DEE  = 1;
    localparam int MIST_B_MFE  = 0;

    // multi-function source fields
    localparam int MIST_B_MAF  = 5;
    localparam int MIST_B_MPF  = 4;
    localparam int MIST_B_MAE  = 1;
    localparam int MIST_B_MPE  = 0;

    // time-base control fields
    localparam int MIST_B_TIMEBASE_MASTER_ON = 7;
    localparam int MIST_B_TIMEBASE_CLOCK_SELECT = 6;
    localparam int MIST_B_TB1L = 4;
    localparam int MIST_B_TB0L = 0;

    // reset values
    localparam logic [1:0] MIST_RST_TB1SEL = 2'h3;
    localparam logic [2:0] MIST_RST_TB0SEL = 3'h7;

    // time-base divider geometry: period = 2**(base + code)
    localparam int MIST_TB0_LOG2_MIN = 8;
    localparam int MIST_TB1_LOG2_MIN = 12;
    localparam int MIST_TB_CNT_W     = 15;
    localparam logic [1:0] MIST_SYS_DIV_LAST = 2'h3;

    // vector codes, in fixed priority order, highest first
    typedef enum logic [1:0] {
        MIST_VEC_MF  = 2'b00,
        MIST_VEC_TB0 = 2'b01,
        MIST_VEC_TB1 = 2'b11,
        MIST_VEC_EE  = 2'b10
    } mist_vec_t;

endpackage

//--- testbench.sv
`timescale 1ns/100ps
module testbench
    import mist_pkg::*;
;
    logic        sys_clk_in, rst_in, osc, wr, rd, mp, ma, ee, stk, ack, rfi, irq, wake;
    logic        slow, return_from_interrupt_en, rd_d;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, w0, w1, w2, w3;
    logic [1:0]  vec;
    logic [31:0] seed;
    logic [7:0]  exp_rd[$];
    mist_vec_t   exp_vec[$];
    int          num_errors, check_count, cyc;
    mist_irq DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .match_p_evt_in(mp), .match_a_evt_in(ma), .eeprom_done_in(ee),
        .timebase_osc_clock_in(osc), .stack_full_in(stk), .vec_ack_in(ack),
        .return_from_interrupt_in(rfi), .irq_req_out(irq), .irq_vec_out(vec), .wake_out(wake));
    mist_core_model u_core (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .irq_req_in(irq),
        .slow_in(slow), .return_from_interrupt_en_in(return_from_interrupt_en), .vec_ack_out(ack), .return_from_interrupt_out(rfi));
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_vec(input mist_vec_t e, input logic [1:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH vector expected %b seen %b", e, g);
        end
    endtask
    task automatic cmp_bit(input string n, input logic e, input logic g);
        cmp8(n, {7'h00, e}, {7'h00, g});
    endtask
    // reads carry their expected value in d
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        wr    <= w;
        rd    <= !w;
        addr  <= a;
        wdata <= d;
        if (!w) exp_rd.push_back(d);
        @(posedge sys_clk_in);
    endtask
    task automatic idle();
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic clear();
        bus(1'b1, MIST_ADDR_MFI, 8'h00);
        bus(1'b1, MIST_ADDR_INTC0, 8'h00);
        bus(1'b1, MIST_ADDR_INTC1, 8'h00);
        idle();
    endtask
    task automatic pulse(input int k, input logic ew, input logic ei);
        mp <= (k == 0);
        ma <= (k == 1);
        ee <= (k == 2);
        @(posedge sys_clk_in);
        mp <= 1'b0;
        ma <= 1'b0;
        ee <= 1'b0;
        #1;
        cmp_bit("wake", ew, wake);
        cmp_bit("irq", ei, irq);
        @(posedge sys_clk_in);
    endtask
    task automatic drain();
        for (int i = 0; i < 30000 && exp_vec.size() > 0; i++) @(posedge sys_clk_in);
    endtask
    task automatic tb_period(input logic [7:0] timebase_control, input int lo, input int hi);
        int t0;
        bus(1'b1, MIST_ADDR_INTC0, 8'h00);
        bus(1'b1, MIST_ADDR_TBC, timebase_control);
        idle();
        @(posedge sys_clk_in iff wake);
        t0 = cyc;
        bus(1'b1, MIST_ADDR_INTC0, 8'h00);
        idle();
        @(posedge sys_clk_in iff wake);
        cmp_bit("period", 1'b1, cyc - t0 >= lo && cyc - t0 <= hi);
        bus(1'b1, MIST_ADDR_TBC, 8'h40);
        idle();
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    // free-running oscillator, phase unrelated to the system clock
    initial begin
        osc = 1'b0;
        #7;
        forever #61 osc = ~osc;
    end
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        rd_d <= rd && !rst_in;
        if (rd_d) cmp8("rdata", exp_rd.pop_front(), rdata);
        if (ack && irq) cmp_vec(exp_vec.pop_front(), vec);
        if (cyc == 80000) begin
            num_errors++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {rst_in, wr, rd, mp, ma, ee, stk, slow, return_from_interrupt_en, rd_d} = 10'b10_0000_0000;
        {addr, wdata, num_errors, check_count, cyc} = '0;
        seed = 32'h0000_0014;
        repeat (20) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        for (int a = 0; a < 8; a++) bus(1'b0, 3'(a), a == 3 ? 8'h37 : 8'h00);
        bus(1'b1, 3'h5, 8'hFF);
        bus(1'b0, 3'h5, 8'h00);
        stk <= 1'b1;
        repeat (4) begin
            {w0, w1, w2, w3} = {rnd(), rnd(), rnd(), rnd() & 8'h77};
            bus(1'b1, MIST_ADDR_INTC1, w1);
            bus(1'b1, MIST_ADDR_MFI, w2);
            bus(1'b1, MIST_ADDR_INTC0, w0);
            bus(1'b1, MIST_ADDR_TBC, w3);
            bus(1'b0, MIST_ADDR_TBC, w3 & 8'hF7);
            bus(1'b0, MIST_ADDR_INTC0, w0 & 8'h6D);
            bus(1'b0, MIST_ADDR_INTC1,
                (w1 & 8'h33) | ((w2 & 8'h03 & (w2 >> 4)) != 0 ? 8'h10 : 8'h00));
            bus(1'b0, MIST_ADDR_MFI, w2 & 8'h33);
            clear();
        end
        stk <= 1'b0;
        slow <= 1'b1;
        return_from_interrupt_en <= 1'b1;
        bus(1'b1, MIST_ADDR_INTC1, 8'h02);
        idle();
        pulse(2, 1'b1, 1'b0);
        bus(1'b0, MIST_ADDR_INTC1, 8'h22);
        stk <= 1'b1;
        bus(1'b1, MIST_ADDR_INTC0, 8'h01);
        idle();
        repeat (3) @(posedge sys_clk_in);
        cmp_bit("irq", 1'b0, irq);
        exp_vec.push_back(MIST_VEC_EE);
        stk <= 1'b0;
        drain();
        bus(1'b0, MIST_ADDR_INTC1, 8'h02);
        bus(1'b0, MIST_ADDR_INTC0, 8'h00);
        idle();
        repeat (8) @(posedge sys_clk_in);
        bus(1'b0, MIST_ADDR_INTC0, 8'h01);
        clear();
        return_from_interrupt_en <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            slow <= k[0];
            bus(1'b1, MIST_ADDR_MFI, 8'h01 << k);
            bus(1'b1, MIST_ADDR_INTC1, 8'h01);
            bus(1'b1, MIST_ADDR_INTC0, 8'h01);
            idle();
            exp_vec.push_back(MIST_VEC_MF);
            pulse(k, 1'b1, 1'b1);
            drain();
            repeat (10) @(posedge sys_clk_in);
            bus(1'b0, MIST_ADDR_MFI, 8'h11 << k);
            bus(1'b0, MIST_ADDR_INTC1, 8'h01);
            bus(1'b0, MIST_ADDR_INTC0, 8'h00);
            clear();
        end
        bus(1'b1, MIST_ADDR_INTC1, 8'h01);
        bus(1'b1, MIST_ADDR_INTC0, 8'h01);
        idle();
        pulse(0, 1'b1, 1'b0);
        bus(1'b0, MIST_ADDR_MFI, 8'h10);
        bus(1'b0, MIST_ADDR_INTC1, 8'h01);
        clear();
        slow <= 1'b0;
        return_from_interrupt_en <= 1'b1;
        bus(1'b1, MIST_ADDR_INTC1, 8'h33);
        exp_vec = '{MIST_VEC_MF, MIST_VEC_TB0, MIST_VEC_TB1, MIST_VEC_EE};
        bus(1'b1, MIST_ADDR_INTC0, 8'h6D);
        idle();
        drain();
        repeat (10) @(posedge sys_clk_in);
        bus(1'b0, MIST_ADDR_INTC1, 8'h03);
        bus(1'b0, MIST_ADDR_INTC0, 8'h0D);
        clear();
        for (int c = 0; c < 2; c++) tb_period(8'hC0 | 8'(c), 1024 << c, 1024 << c);
        tb_period(8'h80, 1559, 1564);
        bus(1'b1, MIST_ADDR_INTC0, 8'h00);
        idle();
        repeat (1100) @(posedge sys_clk_in);
        bus(1'b0, MIST_ADDR_INTC0, 8'h00);
        exp_vec.push_back(MIST_VEC_TB1);
        bus(1'b1, MIST_ADDR_INTC0, 8'h09);
        bus(1'b1, MIST_ADDR_TBC, 8'hC7);
        idle();
        drain();
        bus(1'b1, MIST_ADDR_TBC, 8'h47);
        idle();
        cmp8("vectors left", 8'h00, 8'(exp_vec.size()));
        test_done();
    end
endmodule
